/* hdl/pbaarb_pkg.sv */
package pbaarb_pkg;

  // Register map
  localparam logic [11:0] ARB_CTRL_OFF   = 12'h2D0;
  localparam int          EN_LSB         = 17;
  localparam int          PRI_LSB        = 8;
  localparam int          DLY_BIT        = 3;
  localparam int          PARK_MODE_BIT  = 2;
  localparam int          PARK_SEL_LSB   = 0;

  // Reset values
  localparam logic [2:0]  EN_RST_PCI     = 3'h0;
  localparam logic [2:0]  EN_RST_PB      = 3'h1;
  localparam logic [3:0]  PRI_RST        = 4'h0;
  localparam logic [1:0]  PARK_SEL_RST   = 2'h0;

  // Master numbering: 0 is the device's own master, 1..3 external
  localparam logic [1:0]  OWN_ID         = 2'h0;
  localparam int          NUM_MASTERS    = 4;

  // Counter load after transfer start; requests are sampled this many clocks plus one later
  localparam logic [1:0]  DLY_SHORT_CNT  = 2'h0;
  localparam logic [1:0]  DLY_LONG_CNT   = 2'h1;

  typedef struct packed {
    logic [2:0] en;
    logic [3:0] pri;
    logic       dly;
    logic       park_mode;
    logic [1:0] park_sel;
  } pbaarb_ctrl_t;

  typedef enum logic {
    ARB_OPEN,
    ARB_HOLD
  } pbaarb_state_t;

endpackage

/* hdl/pbaarb_pick.sv */
`timescale 1ns/1ps
module pbaarb_pick #(
  parameter int N = 4
) (
  // Requests and priority
  input  wire logic [N-1:0]         i_req,
  input  wire logic [N-1:0]         i_hi,
  input  wire logic [$clog2(N)-1:0] i_last,
  // Result
  output logic                      o_valid,
  output logic [$clog2(N)-1:0]      o_win
);

  localparam int W = $clog2(N);

  // Refused at elaboration: the rotating search wraps by bit width
  if (N != (1 << W) || N < 2) begin : g_bad_n
    $error("pbaarb_pick: N must be a power of two of at least 2");
  end

  logic [W-1:0] idx;
  logic         found_hi;
  logic         found_lo;
  logic [W-1:0] win_hi;
  logic [W-1:0] win_lo;

  // Search starts one past the last winner so equals take turns
  always_comb begin
    idx      = '0;
    found_hi = 1'b0;
    found_lo = 1'b0;
    win_hi   = '0;
    win_lo   = '0;
    for (int i = 1; i <= N; i++) begin
      idx = W'(i_last + W'(i));
      if (i_req[idx] && i_hi[idx] && !found_hi) begin
        found_hi = 1'b1;
        win_hi   = idx;
      end
      if (i_req[idx] && !found_lo) begin
        found_lo = 1'b1;
        win_lo   = idx;
      end
    end
    o_valid = found_lo;
    o_win   = found_hi ? win_hi : win_lo;
  end

endmodule

/* hdl/pbaarb_top.sv */
// Chosen here: the strobed register port.
`timescale 1ns/1ps
// Function
// - Requests of an external master count only while its enable bit is 1.
// - Each external master has a priority bit: 0 low, 1 high.
// - The own master also has a priority bit and competes with the others.
// - Requests are not sampled until the post-start delay expires; only those still present then can win.
// - Park mode 1 parks on the selected master, 0 on the last granted.
// - Park select 00 own, 01 master 1, 10 master 2, 11 master 3.
// - Reset enables: none on PCI boot, master 1 only on processor bus boot.
// - Reset clears priorities, delay, park mode and park select; all read/write.
module pbaarb_top (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  // Register port
  input  wire logic [11:0] i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [31:0] o_rdata,
  // Boot strap, 1 selects PCI boot
  input  wire logic        i_boot_source_option,
  // Processor bus pins, active low
  input  wire logic        i_transfer_start_n,
  input  wire logic [2:0]  i_ext_bus_request_pin_n,
  output logic      [2:0]  o_ext_bus_grant_pin_n,
  // Own master
  input  wire logic        i_own_req,
  output logic             o_own_grant
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; the first stage feeds only the second

  logic [2:0] req_meta_q;
  logic [2:0] req_sync_q;
  logic       ts_meta_q;
  logic       ts_sync_q;
  logic       boot_meta_q;
  logic       boot_sync_q;

  always_ff @(posedge i_clk) begin
    req_meta_q  <= ~i_ext_bus_request_pin_n;
    req_sync_q  <= req_meta_q;
    ts_meta_q   <= ~i_transfer_start_n;
    ts_sync_q   <= ts_meta_q;
    boot_meta_q <= i_boot_source_option;
    boot_sync_q <= boot_meta_q;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control register

  pbaarb_pkg::pbaarb_ctrl_t ctrl_q;
  logic                     hit;
  logic [31:0]              ctrl_word;

  assign hit = (i_addr == pbaarb_pkg::ARB_CTRL_OFF);

  always_comb begin
    ctrl_word = 32'h0000_0000;
    ctrl_word[pbaarb_pkg::EN_LSB +: 3]       = ctrl_q.en;
    ctrl_word[pbaarb_pkg::PRI_LSB +: 4]      = ctrl_q.pri;
    ctrl_word[pbaarb_pkg::DLY_BIT]           = ctrl_q.dly;
    ctrl_word[pbaarb_pkg::PARK_MODE_BIT]     = ctrl_q.park_mode;
    ctrl_word[pbaarb_pkg::PARK_SEL_LSB +: 2] = ctrl_q.park_sel;
  end

  // Strap is read through the synchroniser, so hold reset three clocks
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ctrl_q.en        <= boot_sync_q ? pbaarb_pkg::EN_RST_PCI
                                      : pbaarb_pkg::EN_RST_PB;
      ctrl_q.pri       <= pbaarb_pkg::PRI_RST;
      ctrl_q.dly       <= 1'b0;
      ctrl_q.park_mode <= 1'b0;
      ctrl_q.park_sel  <= pbaarb_pkg::PARK_SEL_RST;
    end else if (i_wr && hit) begin
      ctrl_q.en        <= i_wdata[pbaarb_pkg::EN_LSB +: 3];
      ctrl_q.pri       <= i_wdata[pbaarb_pkg::PRI_LSB +: 4];
      ctrl_q.dly       <= i_wdata[pbaarb_pkg::DLY_BIT];
      ctrl_q.park_mode <= i_wdata[pbaarb_pkg::PARK_MODE_BIT];
      ctrl_q.park_sel  <= i_wdata[pbaarb_pkg::PARK_SEL_LSB +: 2];
    end
  end

  // Unmapped reads return zero
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_rdata <= 32'h0000_0000;
    end else if (i_rd) begin
      o_rdata <= hit ? ctrl_word : 32'h0000_0000;
    end else begin
      o_rdata <= 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Arbitration

  pbaarb_pkg::pbaarb_state_t state_q;
  logic [1:0] cnt_q;
  logic [1:0] owner_q;
  logic [1:0] owner_d;
  logic [1:0] last_q;
  logic [3:0] req_vec;
  logic       arb_now;
  logic       pick_valid;
  logic [1:0] pick_win;
  logic [3:0] owner_oh;

  function automatic logic [3:0] onehot(input logic [1:0] id);
    onehot     = 4'h0;
    onehot[id] = 1'b1;
  endfunction

  assign req_vec = {req_sync_q & ctrl_q.en, i_own_req};

  // Held-over requests are never looked at while the wait runs
  always_comb begin
    case (state_q)
      pbaarb_pkg::ARB_OPEN: arb_now = !ts_sync_q;
      pbaarb_pkg::ARB_HOLD: arb_now = (cnt_q == 2'h0);
      default:              arb_now = 1'b0;
    endcase
  end

  pbaarb_pick #(
    .N       (pbaarb_pkg::NUM_MASTERS)
  ) u_pick (
    .i_req   (req_vec),
    .i_hi    (ctrl_q.pri),
    .i_last  (last_q),
    .o_valid (pick_valid),
    .o_win   (pick_win)
  );

  always_comb begin
    owner_d = owner_q;
    if (arb_now) begin
      if (pick_valid) begin
        owner_d = pick_win;
      end else if (ctrl_q.park_mode) begin
        owner_d = ctrl_q.park_sel;
      end else begin
        owner_d = last_q;
      end
    end
  end

  assign owner_oh = onehot(owner_d);

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_q <= pbaarb_pkg::ARB_OPEN;
      cnt_q   <= 2'h0;
    end else begin
      case (state_q)
        pbaarb_pkg::ARB_OPEN: begin
          if (ts_sync_q) begin
            state_q <= pbaarb_pkg::ARB_HOLD;
            cnt_q   <= ctrl_q.dly ? pbaarb_pkg::DLY_LONG_CNT
                                  : pbaarb_pkg::DLY_SHORT_CNT;
          end
        end
        pbaarb_pkg::ARB_HOLD: begin
          if (cnt_q == 2'h0) begin
            state_q <= pbaarb_pkg::ARB_OPEN;
          end else begin
            cnt_q <= cnt_q - 2'h1;
          end
        end
        default: state_q <= pbaarb_pkg::ARB_OPEN;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      owner_q <= pbaarb_pkg::OWN_ID;
      last_q  <= pbaarb_pkg::OWN_ID;
    end else begin
      owner_q <= owner_d;
      if (arb_now && pick_valid) begin
        last_q <= pick_win;
      end
    end
  end

  // Grant pins follow the owner; the bus always has exactly one owner
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_ext_bus_grant_pin_n <= 3'h7;
      o_own_grant           <= 1'b1;
    end else begin
      o_ext_bus_grant_pin_n <= ~owner_oh[3:1];
      o_own_grant           <= owner_oh[0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  a_win_enabled: assert property (@(posedge i_clk) disable iff (i_rst)
    arb_now && pick_valid && pick_win != 2'h0 |-> ctrl_q.en[pick_win - 2'h1])
    else $error("grant to a disabled external master");

  a_high_first: assert property (@(posedge i_clk) disable iff (i_rst)
    arb_now && |(req_vec & ctrl_q.pri) |-> ctrl_q.pri[pick_win] && req_vec[pick_win])
    else $error("low priority master beat a high priority one");

  a_short_wait: assert property (@(posedge i_clk) disable iff (i_rst)
    state_q == pbaarb_pkg::ARB_OPEN && ts_sync_q && !ctrl_q.dly |=> arb_now)
    else $error("requests not sampled one clock after start");

  a_long_wait: assert property (@(posedge i_clk) disable iff (i_rst)
    state_q == pbaarb_pkg::ARB_OPEN && ts_sync_q && ctrl_q.dly
      |=> !arb_now && $stable(owner_q) ##1 arb_now)
    else $error("requests sampled early after start");

  a_park_fixed: assert property (@(posedge i_clk) disable iff (i_rst)
    arb_now && !pick_valid && ctrl_q.park_mode
      |=> owner_q == $past(ctrl_q.park_sel) && !o_own_grant == (owner_q != 2'h0))
    else $error("bus not parked on selected master");

  a_park_last: assert property (@(posedge i_clk) disable iff (i_rst)
    arb_now && !pick_valid && !ctrl_q.park_mode |=> owner_q == $past(last_q))
    else $error("bus not parked on last master");

  a_reset_vals: assert property (@(posedge i_clk)
    $past(i_rst) && !i_rst |-> ctrl_q.en == ($past(boot_sync_q) ? 3'h0 : 3'h1)
      && ctrl_q.pri == 4'h0 && !ctrl_q.dly && !ctrl_q.park_mode && ctrl_q.park_sel == 2'h0)
    else $error("control register reset values wrong");

  a_read_back: assert property (@(posedge i_clk) disable iff (i_rst)
    i_wr && hit ##1 i_rd && hit && !i_wr
      |=> o_rdata == ($past(i_wdata, 2) & 32'h000E_0F0F))
    else $error("control register read-back mismatch");

  a_one_grant: assert property (@(posedge i_clk) disable iff (i_rst)
    $onehot({~o_ext_bus_grant_pin_n, o_own_grant}))
    else $error("grant pins not one-hot");

  c_park_m3: cover property (@(posedge i_clk) disable iff (i_rst)
    arb_now && !pick_valid && ctrl_q.park_mode && ctrl_q.park_sel == 2'h3);
  c_high_win: cover property (@(posedge i_clk) disable iff (i_rst)
    arb_now && pick_valid && ctrl_q.pri[pick_win] && req_vec[0] && pick_win != 2'h0);
  c_long_wait: cover property (@(posedge i_clk) disable iff (i_rst)
    state_q == pbaarb_pkg::ARB_HOLD && cnt_q == 2'h1);

endmodule

/* sim/pbaarb_masters.sv */
`timescale 1ns/1ps
// External masters: start a transfer once granted
module pbaarb_masters (
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  // Bench control
  input  wire logic [2:0] i_want,
  input  wire logic [1:0] i_hold,
  // Bus pins, active low
  input  wire logic [2:0] i_grant_n,
  output logic      [2:0] o_req_n,
  output logic            o_ts_n
);
  logic [2:0] done_q;
  logic [1:0] hold_q;
  // Pull-ups take a released request high; holdover mimics a slow cache
  assign o_req_n = ~(i_want & (~done_q | {3{hold_q != 2'h0}}));
  always_ff @(posedge i_clk) begin
    o_ts_n <= 1'b1;
    done_q <= done_q & i_want;
    if (hold_q != 2'h0)
      hold_q <= hold_q - 2'h1;
    for (int i = 0; i < 3; i++) begin
      if (i_want[i] && !done_q[i] && !i_grant_n[i] && o_ts_n && !i_rst) begin
        o_ts_n    <= 1'b0;
        done_q[i] <= 1'b1;
        hold_q    <= i_hold;
      end
    end
    if (i_rst) begin
      done_q <= 3'h0;
      hold_q <= 2'h0;
    end
  end
endmodule

/* sim/tb.sv */
`timescale 1ns/1ps
module tb;
  logic        clk;
  logic        rst;
  logic [11:0] addr;
  logic [31:0] wdata;
  logic        wr;
  logic        rd;
  logic [31:0] rdata;
  logic        boot;
  logic        ts_n;
  logic [2:0]  req_n;
  logic [2:0]  gnt_n;
  logic        own_req;
  logic        own_gnt;
  logic [2:0]  want;
  logic [1:0]  hold;
  logic [3:0]  gnt;
  logic [31:0] exp_q[$];
  logic        rd_d;
  logic [31:0] d;
  int          n_errors;
  int          check_count;
  int          cyc;
  int          seed;
  assign gnt = {~gnt_n, own_gnt};
  pbaarb_top pbaarb_top_i (.i_clk(clk), .i_rst(rst), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_boot_source_option(boot),
    .i_transfer_start_n(ts_n), .i_ext_bus_request_pin_n(req_n),
    .o_ext_bus_grant_pin_n(gnt_n), .i_own_req(own_req), .o_own_grant(own_gnt));
  pbaarb_masters pbaarb_masters_i (.i_clk(clk), .i_rst(rst), .i_want(want), .i_hold(hold),
    .i_grant_n(gnt_n), .o_req_n(req_n), .o_ts_n(ts_n));
  ////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr_reg(input logic [11:0] a, input logic [31:0] v);
    @(posedge clk);
    addr  <= a;
    wdata <= v;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // Expected read data is queued; the monitor compares it later
  task automatic rd_reg(input logic [11:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    exp_q.push_back(v);
    @(posedge clk);
    rd <= 1'b0;
  endtask
  // Write then read back with no idle cycle between the strobes
  task automatic wr_rd_reg(input logic [11:0] a, input logic [31:0] v, input logic [31:0] e);
    @(posedge clk);
    addr  <= a;
    wdata <= v;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b1;
    exp_q.push_back(e);
    @(posedge clk);
    rd <= 1'b0;
  endtask
  task automatic do_reset(input logic b);
    @(posedge clk);
    boot <= b;
    rst  <= 1'b1;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
  endtask
  ////////////////////////////////////////
  always @(posedge clk) begin
    #1;
    if (rd_d)
      chk(rdata, exp_q.pop_front());
    else
      chk(rdata, 32'h0);
    rd_d = rd;
  end
  // Bench needs well under a thousand cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc > 3000) begin
      n_errors++;
      final_report();
    end
  end
  ////////////////////////////////////////
  initial begin
    seed = 77;
    n_errors = 0;
    check_count = 0;
    cyc = 0;
    rd_d = 1'b0;
    rst = 1'b1;
    addr = 12'h0;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
    boot = 1'b1;
    own_req = 1'b0;
    want = 3'h0;
    hold = 2'h0;
    do_reset(1'b1);
    wait_cyc(1);
    chk({28'h0, gnt}, 32'h1);
    rd_reg(pbaarb_pkg::ARB_CTRL_OFF, 32'h0);
    for (int i = 0; i < 4; i++) begin
      d = $random(seed);
      wr_rd_reg(pbaarb_pkg::ARB_CTRL_OFF, d, d & 32'h000E0F0F);
      rd_reg(pbaarb_pkg::ARB_CTRL_OFF, d & 32'h000E0F0F);
    end
    wr_reg(12'h2D4, 32'hFFFFFFFF);
    rd_reg(12'h2D4, 32'h0);
    rd_reg(pbaarb_pkg::ARB_CTRL_OFF, d & 32'h000E0F0F);
    for (int s = 0; s < 4; s++) begin
      wr_reg(pbaarb_pkg::ARB_CTRL_OFF, 32'h4 | 32'(s));
      wait_cyc(4);
      chk({28'h0, gnt}, 32'h1 << s);
    end
    do_reset(1'b0);
    wait_cyc(1);
    rd_reg(pbaarb_pkg::ARB_CTRL_OFF, 32'h00020000);
    @(posedge clk);
    want <= 3'h2;
    wait_cyc(5);
    chk({28'h0, gnt}, 32'h1);
    wr_reg(pbaarb_pkg::ARB_CTRL_OFF, 32'h00060000);
    wait_cyc(3);
    chk({28'h0, gnt}, 32'h4);
    wait_cyc(3);
    chk({28'h0, gnt}, 32'h4);
    @(posedge clk);
    want <= 3'h0;
    wait_cyc(6);
    for (int k = 0; k < 4; k++) begin
      wr_reg(pbaarb_pkg::ARB_CTRL_OFF, 32'h000E0000 | (32'h100 << k));
      @(posedge clk);
      want <= 3'h7;
      own_req <= 1'b1;
      wait_cyc(3);
      chk({28'h0, gnt}, 32'h1 << k);
      @(posedge clk);
      want <= 3'h0;
      own_req <= 1'b0;
      wait_cyc(8);
    end
    // Master 1 holds its request one clock past its start
    for (int dl = 0; dl < 2; dl++) begin
      wr_reg(pbaarb_pkg::ARB_CTRL_OFF, 32'h00020200 | (32'(dl) << 3));
      @(posedge clk);
      hold <= 2'h1;
      own_req <= 1'b1;
      want <= 3'h1;
      for (int n = 0; n < 20 && ts_n !== 1'b0; n++)
        wait_cyc(1);
      chk({28'h0, gnt}, 32'h2);
      wait_cyc(4);
      chk({28'h0, gnt}, (dl == 1) ? 32'h2 : 32'h1);
      wait_cyc(1);
      chk({28'h0, gnt}, 32'h1);
      @(posedge clk);
      want <= 3'h0;
      own_req <= 1'b0;
      wait_cyc(8);
    end
    final_report();
  end
endmodule
